/* File: logic/canirq_defines.svh */
// Constants of the interrupt code encoder: register map, field positions, resets and codes
// What this block does
// R1: Pending sources are ranked by fixed priority; code values do not follow rank. Here legacy tx0 (code 4) outranks tx2 (code 2).
// R2: When the top condition clears, the code moves to the next pending or none.
// R3: Only a source with flag and enable both set takes part in the code.
// R4: Legacy mode shows a 3-bit code, enhanced and FIFO modes a 5-bit code.
// R5: In FIFO mode every receive interrupt gives extended code 10000.
// R6: With transmit interrupts enabled, an emptied transmit buffer raises a transmit interrupt.
// R7: Legacy mode: each of three transmit buffers has its own enable and flag.
// R8: Legacy mode: software clears a transmit flag by writing zero; device holds it.
// R9: Enhanced and FIFO modes: one shared transmit enable and flag; per-buffer bits unused.
// R10: Enhanced and FIFO modes: per-buffer enables gate contribution to shared interrupts.
// R11: On shared transmit interrupt, software polls each buffer's transmit request bit.
// R12: With receive interrupts enabled, a good stored frame raises receive interrupt after EOF.
// R13: Legacy mode: per-buffer receive flag shows the source; software writes zero to clear.
// R14: Enhanced and FIFO modes: one shared receive enable, flag and priority bit; the block has no priority bit, only the shared enable and flag.
// R15: Enhanced mode: software checks each receive buffer-full bit to find the source.
// R16: FIFO mode: receive interrupt means a new FIFO message; read pointer names next buffer.
// R17: Legacy codes: 0 none,1 error,2 tx2,3 tx1,4 tx0,5 rx1,6 rx0,7 wake-up.
// R18: Any message error sets the message-error flag; interrupt only if its enable set.
// R19: FIFO read pointer is four bits; 0 to 7 select buffers, higher reserved.
// R20: The code is recomputed every clock from current flags and enables.
`ifndef CANIRQ_DEFINES_SVH
`define CANIRQ_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CANIRQ_OFS_MODE 12'h000
`define CANIRQ_OFS_STATUS 12'h004
`define CANIRQ_OFS_FLAGS 12'h008
`define CANIRQ_OFS_ENABLES 12'h00c
`define CANIRQ_OFS_BUFEN 12'h010
`define CANIRQ_OFS_FIFO 12'h014

// ------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------
`define CANIRQ_STAT_LEG_LSB 1
`define CANIRQ_NBUF 8
`define CANIRQ_NTX 3
`define CANIRQ_PTR_W 4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CANIRQ_RST_MODE 2'h0
`define CANIRQ_RST_FLAGS 10'h000
`define CANIRQ_RST_EN 10'h000
`define CANIRQ_RST_BUFEN 8'h00
`define CANIRQ_RST_PTR 4'h0

// ------------------------------------------------------------
// Codes
// ------------------------------------------------------------
`define CANIRQ_LC_NONE 3'h0
`define CANIRQ_LC_ERR 3'h1
`define CANIRQ_LC_TX2 3'h2
`define CANIRQ_LC_TX1 3'h3
`define CANIRQ_LC_TX0 3'h4
`define CANIRQ_LC_RX1 3'h5
`define CANIRQ_LC_RX0 3'h6
`define CANIRQ_LC_WAK 3'h7
`define CANIRQ_EC_NONE 5'h00
`define CANIRQ_EC_ERR 5'h02
`define CANIRQ_EC_TX 5'h04
`define CANIRQ_EC_RXE 5'h0c
`define CANIRQ_EC_MERR 5'h0e
`define CANIRQ_EC_WAK 5'h0f
`define CANIRQ_EC_FIFO 5'h10

`endif

/* File: logic/canirq_pkg.sv */
// Types shared by the interrupt code encoder files
package canirq_pkg;

    typedef enum logic [1:0] {
        CANIRQ_MODE_LEGACY = 2'b00,
        CANIRQ_MODE_ENH = 2'b01,
        CANIRQ_MODE_FIFO = 2'b10
    } canirq_mode_t;

    // Sticky flags, one bit per source
    typedef struct packed {
        logic merr;
        logic wak;
        logic err;
        logic rx_shared;
        logic tx_shared;
        logic rx1;
        logic rx0;
        logic tx2;
        logic tx1;
        logic tx0;
    } canirq_src_t;

endpackage

/* File: logic/canirq_apb_slave.sv */
// APB slave decode for the interrupt code encoder registers
`timescale 1ns/100ps
`include "canirq_defines.svh"
module canirq_apb_slave (
    input wire logic ref_clk_i, // System clock
    input wire logic sys_rst_i, // Async reset, active high
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB direction
    input wire logic [11:0] paddr_i, // APB byte address
    input wire logic [31:0] pwdata_i, // APB write data
    input wire logic [31:0] rdata_mux_i, // Read data of the addressed register
    input wire logic hit_i, // Address is mapped
    output logic wr_stb_o, // One-cycle write strobe
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o // APB error
);
    // ------------------------------------------------------------
    // Zero-wait access: the access phase completes in its first cycle
    // ------------------------------------------------------------
    wire logic setup_w;
    assign setup_w = psel_i && !penable_i;
    assign wr_stb_o = psel_i && penable_i && pwrite_i && hit_i;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= setup_w;
            pslverr_o <= setup_w && !hit_i;
            prdata_o <= (setup_w && !pwrite_i && hit_i) ? rdata_mux_i : 32'h0000_0000;
        end
    end
endmodule // canirq_apb_slave

/* File: logic/canirq_prio_enc.sv */
// Priority encoder turning pending enabled sources into legacy and extended codes
`timescale 1ns/100ps
`include "canirq_defines.svh"
module canirq_prio_enc (
    input wire canirq_pkg::canirq_mode_t mode_i, // Operating mode
    input wire canirq_pkg::canirq_src_t act_i, // Flag and enable both set
    output logic [2:0] leg_code_o, // Three-bit code
    output logic [4:0] ext_code_o // Five-bit code
);
    // ------------------------------------------------------------
    // Fixed priority, most urgent first; code values do not rise with rank (tx0 is 4, tx2 is 2)
    // ------------------------------------------------------------
    always_comb begin
        if (act_i.err) leg_code_o = `CANIRQ_LC_ERR; // R1 R17
        else if (act_i.tx0) leg_code_o = `CANIRQ_LC_TX0; // R17
        else if (act_i.tx1) leg_code_o = `CANIRQ_LC_TX1; // R17
        else if (act_i.tx2) leg_code_o = `CANIRQ_LC_TX2; // R17
        else if (act_i.rx0) leg_code_o = `CANIRQ_LC_RX0; // R17
        else if (act_i.rx1) leg_code_o = `CANIRQ_LC_RX1; // R17
        else if (act_i.wak) leg_code_o = `CANIRQ_LC_WAK; // R17
        else leg_code_o = `CANIRQ_LC_NONE; // R2
    end

    always_comb begin
        if (act_i.err) ext_code_o = `CANIRQ_EC_ERR; // R1
        else if (act_i.tx_shared) ext_code_o = `CANIRQ_EC_TX; // R9
        else if (act_i.rx_shared) ext_code_o = (mode_i == canirq_pkg::CANIRQ_MODE_FIFO) ?
            `CANIRQ_EC_FIFO : `CANIRQ_EC_RXE; // R5 R14
        else if (act_i.merr) ext_code_o = `CANIRQ_EC_MERR; // R18
        else if (act_i.wak) ext_code_o = `CANIRQ_EC_WAK;
        else ext_code_o = `CANIRQ_EC_NONE; // R2
    end
endmodule // canirq_prio_enc

/* File: logic/canirq_top.sv */
// Interrupt flag, enable and code logic of the CAN controller with APB access
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "canirq_defines.svh"
module canirq_top #(
    parameter int NBUF = `CANIRQ_NBUF // Message buffers in FIFO mode
) (
    input wire logic ref_clk_i, // System clock, 25 MHz
    input wire logic sys_rst_i, // Async reset, active high
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB direction
    input wire logic [11:0] paddr_i, // APB byte address
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o, // APB error
    input wire logic [2:0] tx_empty_i, // Pulse: transmit buffer n became empty
    input wire logic [1:0] rx_done_i, // Pulse: legacy receive buffer n loaded after EOF
    input wire logic [NBUF-1:0] buf_tx_done_i, // Pulse: buffer completed transmission
    input wire logic [NBUF-1:0] buf_rx_done_i, // Pulse: buffer loaded after EOF
    input wire logic bus_err_i, // Pulse: bus error condition
    input wire logic msg_err_i, // Pulse: error while sending or receiving
    input wire logic wake_i, // Pulse: bus activity while asleep
    output logic irq_o, // Any enabled source pending
    output logic [7:0] controller_status_reg_o // Code field as it reads in status
);
    // Refused at elaboration: the pointer and enable fields hold at most eight buffers
    if (NBUF < 1 || NBUF > 8) begin : g_nbuf_check
        $error("NBUF must be 1 to 8");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    canirq_pkg::canirq_mode_t mode_r;
    canirq_pkg::canirq_src_t flag_r, flag_nxt;
    canirq_pkg::canirq_src_t en_r;
    logic [7:0] buffer_irq_enables_r;
    logic [3:0] fifo_read_pointer_r;
    logic [7:0] stat_r;
    logic irq_r;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    wire logic wr_stb;
    wire logic [31:0] rdata_mux;
    wire logic sel_mode, sel_stat, sel_flag, sel_en, sel_bufen, sel_fifo, hit;
    assign sel_mode = paddr_i == `CANIRQ_OFS_MODE;
    assign sel_stat = paddr_i == `CANIRQ_OFS_STATUS;
    assign sel_flag = paddr_i == `CANIRQ_OFS_FLAGS;
    assign sel_en = paddr_i == `CANIRQ_OFS_ENABLES;
    assign sel_bufen = paddr_i == `CANIRQ_OFS_BUFEN;
    assign sel_fifo = paddr_i == `CANIRQ_OFS_FIFO;
    assign hit = sel_mode | sel_stat | sel_flag | sel_en | sel_bufen | sel_fifo;
    assign rdata_mux = sel_mode ? {30'h0, mode_r} :
                       sel_stat ? {24'h0, stat_r} :
                       sel_flag ? {22'h0, flag_r} :
                       sel_en ? {22'h0, en_r} :
                       sel_bufen ? {24'h0, buffer_irq_enables_r} :
                       sel_fifo ? {28'h0, fifo_read_pointer_r} : 32'h0000_0000;

    canirq_apb_slave u_apb (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .rdata_mux_i(rdata_mux),
        .hit_i(hit),
        .wr_stb_o(wr_stb),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o)
    );

    // ------------------------------------------------------------
    // Source events
    // ------------------------------------------------------------
    // Per-buffer enables gate only the shared flags; legacy flags ignore them
    wire logic legacy;
    wire logic [7:0] tx_pad, rx_pad;
    wire logic tx_shared_ev, rx_shared_ev;
    wire canirq_pkg::canirq_src_t set_ev;
    wire canirq_pkg::canirq_src_t wr_flag;
    assign legacy = mode_r == canirq_pkg::CANIRQ_MODE_LEGACY;
    assign tx_pad = 8'(buf_tx_done_i);
    assign rx_pad = 8'(buf_rx_done_i);
    assign tx_shared_ev = !legacy && |(tx_pad & buffer_irq_enables_r); // R9 R10
    assign rx_shared_ev = !legacy && |(rx_pad & buffer_irq_enables_r); // R10 R12 R14 R16
    assign set_ev.tx0 = legacy && tx_empty_i[0]; // R6 R7
    assign set_ev.tx1 = legacy && tx_empty_i[1]; // R6 R7
    assign set_ev.tx2 = legacy && tx_empty_i[2]; // R6 R7
    assign set_ev.rx0 = legacy && rx_done_i[0]; // R12 R13
    assign set_ev.rx1 = legacy && rx_done_i[1]; // R12 R13
    assign set_ev.tx_shared = tx_shared_ev;
    assign set_ev.rx_shared = rx_shared_ev;
    assign set_ev.err = bus_err_i;
    assign set_ev.wak = wake_i;
    assign set_ev.merr = msg_err_i; // R18
    assign wr_flag = canirq_pkg::canirq_src_t'(pwdata_i[9:0]);

    // Software can only clear flags by writing zero; a new event wins over a clear
    always_comb begin
        flag_nxt = flag_r;
        if (wr_stb && sel_flag) begin
            flag_nxt = flag_r & wr_flag; // R8 R13
        end
        flag_nxt = flag_nxt | set_ev;
    end

    // ------------------------------------------------------------
    // Code generation
    // ------------------------------------------------------------
    wire canirq_pkg::canirq_src_t act;
    wire canirq_pkg::canirq_src_t mode_mask;
    wire logic [2:0] leg_code;
    wire logic [4:0] ext_code;
    // Per-buffer bits are dead outside legacy mode and shared bits dead inside it
    assign mode_mask = legacy ? canirq_pkg::canirq_src_t'(10'h39f) :
                                canirq_pkg::canirq_src_t'(10'h3e0); // R9 R14
    assign act = flag_r & en_r & mode_mask; // R3

    canirq_prio_enc u_enc (
        .mode_i(mode_r),
        .act_i(act),
        .leg_code_o(leg_code),
        .ext_code_o(ext_code)
    );

    wire logic [7:0] stat_nxt;
    assign stat_nxt = legacy ? {4'h0, leg_code, 1'b0} : {3'h0, ext_code}; // R4

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_r <= canirq_pkg::CANIRQ_MODE_LEGACY;
            flag_r <= canirq_pkg::canirq_src_t'(`CANIRQ_RST_FLAGS);
            en_r <= canirq_pkg::canirq_src_t'(`CANIRQ_RST_EN);
            buffer_irq_enables_r <= `CANIRQ_RST_BUFEN;
            stat_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            stat_r <= stat_nxt; // R2 R20
            irq_r <= |act;
            if (wr_stb && sel_mode && pwdata_i[1:0] != 2'b11) begin
                mode_r <= canirq_pkg::canirq_mode_t'(pwdata_i[1:0]);
            end
            if (wr_stb && sel_en) begin
                en_r <= canirq_pkg::canirq_src_t'(pwdata_i[9:0]);
            end
            if (wr_stb && sel_bufen) begin
                buffer_irq_enables_r <= pwdata_i[7:0];
            end
        end
    end

    // FIFO read pointer: advanced by software writes; reserved values refused
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fifo_read_pointer_r <= `CANIRQ_RST_PTR;
        end else if (wr_stb && sel_fifo && !pwdata_i[3] && pwdata_i[3:0] < 4'(NBUF)) begin
            fifo_read_pointer_r <= pwdata_i[3:0]; // R16 R19
        end
    end

    assign irq_o = irq_r;
    assign controller_status_reg_o = stat_r;
endmodule // canirq_top

/* File: bench/canirq_assertions.sv */
// Port checker of the interrupt code encoder
`timescale 1ns/100ps
module canirq_chk #(
    parameter int NBUF = 8
) (
    input wire logic ref_clk_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic psel_i, // Select
    input wire logic penable_i, // Enable
    input wire logic pwrite_i, // Direction
    input wire logic [11:0] paddr_i, // Address
    input wire logic [31:0] pwdata_i, // Write data
    input wire logic [31:0] prdata_o, // Read data
    input wire logic pready_o, // Ready
    input wire logic pslverr_o, // Error
    input wire logic bus_err_i, // Bus error pulse
    input wire logic irq_o, // Interrupt
    input wire logic [7:0] controller_status_reg_o // Code
);
    logic [9:0] en_r;
    logic [1:0] mode_r;
    wire wr_done = psel_i && penable_i && pready_o && pwrite_i;
    wire [7:0] st = controller_status_reg_o;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // ----------------------------------------
    // Shadow of what software asked for
    // ----------------------------------------
    // Mode 3 is refused by the block, so the shadow refuses it too
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_r <= 10'h000;
            mode_r <= 2'h0;
        end else if (wr_done && paddr_i == 12'h00c) begin
            en_r <= pwdata_i[9:0];
        end else if (wr_done && paddr_i == 12'h000 && pwdata_i[1:0] != 2'h3) begin
            mode_r <= pwdata_i[1:0];
        end
    end
    property p_rdy; psel_i && !penable_i |=> pready_o; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_rdy_one; pready_o |=> !pready_o; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
    property p_unmap; psel_i && penable_i && pready_o && paddr_i > 12'h014 |-> pslverr_o; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access without error");
    property p_rd_hi; pready_o && !pwrite_i |-> prdata_o[31:10] == 22'h0; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
    property p_code_irq; st != 8'h00 |-> irq_o; endproperty
    a_code_irq: assert property (p_code_irq) else $error("code shown without interrupt");
    property p_err_top; bus_err_i && en_r[7] |-> ##2 st == 8'h02; endproperty
    a_err_top: assert property (p_err_top) else $error("enabled bus error not on top");
    property p_mask; en_r == 10'h000 && $past(en_r) == 10'h000 |-> !irq_o && st == 8'h00; endproperty
    a_mask: assert property (p_mask) else $error("disabled source reported");
    property p_leg_fmt; mode_r == 2'h0 && $past(mode_r) == 2'h0 |-> st[0] == 1'b0 && st[7:4] == 4'h0; endproperty
    a_leg_fmt: assert property (p_leg_fmt) else $error("legacy code outside its field");
    property p_fifo_rx; mode_r == 2'h2 && $past(mode_r) == 2'h2 |-> st != 8'h0c; endproperty
    a_fifo_rx: assert property (p_fifo_rx) else $error("fifo mode shows buffered receive code");
endmodule // canirq_chk

bind canirq_top canirq_chk #(.NBUF(NBUF)) u_chk (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .bus_err_i(bus_err_i), .irq_o(irq_o),
    .controller_status_reg_o(controller_status_reg_o)
);

/* File: bench/tb_can_interrupt_code_encoder.sv */
// Self-checking bench of the interrupt code encoder
`timescale 1ns/100ps
module tb_can_interrupt_code_encoder;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, se;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] status;
    logic [23:0] ev = 24'h000000;
    int err_count = 0, checked = 0;
    canirq_top #(.NBUF(8)) uut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .tx_empty_i(ev[2:0]), .rx_done_i(ev[4:3]),
        .buf_tx_done_i(ev[12:5]), .buf_rx_done_i(ev[20:13]), .bus_err_i(ev[21]),
        .msg_err_i(ev[22]), .wake_i(ev[23]), .irq_o(irq), .controller_status_reg_o(status)
    );
    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("BAD %s exp %h got %h", nm, exp, got);
            err_count++;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Request held until ready is seen high; a lost ready ends the run
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            err_count++;
            complete_run();
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk("rdata", rd, exp);
        chk("slverr", {31'h0, se}, {31'h0, e});
    endtask
    task automatic step(input logic [11:0] a, input logic [31:0] d, input logic [7:0] exp);
        apb(1'b1, a, d);
        apb(1'b0, 12'h004, 32'h0);
        chk("status_rd", rd, {24'h0, exp});
        chk("status_pin", {24'h0, status}, {24'h0, exp});
    endtask
    task automatic pulse(input logic [23:0] v);
        @(posedge ref_clk_i);
        ev <= v;
        @(posedge ref_clk_i);
        ev <= 24'h000000;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        for (int i = 0; i < 6; i++) begin
            rdchk(12'(i * 4), 32'h0, 1'b0);
        end
        rdchk(12'h020, 32'h0, 1'b1);
        apb(1'b1, 12'h014, 32'h7);
        rdchk(12'h014, 32'h7, 1'b0);
        apb(1'b1, 12'h014, 32'h8);
        rdchk(12'h014, 32'h7, 1'b0);
        apb(1'b1, 12'h000, 32'h3);
        rdchk(12'h000, 32'h0, 1'b0);
        $display("test regs done");
    endtask
    task automatic t_legacy();
        logic [9:0] keep [7] = '{10'h37f, 10'h37e, 10'h37c, 10'h378, 10'h370, 10'h360, 10'h260};
        logic [7:0] code [7] = '{8'h08, 8'h06, 8'h04, 8'h0c, 8'h0a, 8'h0e, 8'h00};
        step(12'h00c, 32'h3ff, 8'h00);
        pulse(24'he0001f);
        rdchk(12'h008, 32'h39f, 1'b0);
        step(12'h008, 32'h3ff, 8'h02);
        for (int i = 0; i < 7; i++) begin
            step(12'h008, {22'h0, keep[i]}, code[i]);
        end
        chk("irq_merr", {31'h0, irq}, 32'h1);
        step(12'h008, 32'h0, 8'h00);
        chk("irq_idle", {31'h0, irq}, 32'h0);
        $display("test legacy done");
    endtask
    task automatic t_mask();
        step(12'h00c, 32'h100, 8'h00);
        pulse(24'ha00000);
        step(12'h00c, 32'h100, 8'h0e);
        step(12'h00c, 32'h180, 8'h02);
        step(12'h008, 32'h0, 8'h00);
        $display("test mask done");
    endtask
    task automatic t_ext();
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h010, 32'h1);
        rdchk(12'h010, 32'h1, 1'b0);
        step(12'h00c, 32'h3e0, 8'h00);
        pulse(24'h00005f);
        step(12'h008, 32'h3ff, 8'h00);
        pulse(24'he02020);
        rdchk(12'h008, 32'h3e0, 1'b0);
        step(12'h008, 32'h3ff, 8'h02);
        step(12'h008, 32'h37f, 8'h04);
        step(12'h008, 32'h35f, 8'h0c);
        step(12'h000, 32'h2, 8'h10);
        step(12'h008, 32'h31f, 8'h0e);
        step(12'h008, 32'h11f, 8'h0f);
        step(12'h008, 32'h01f, 8'h00);
        $display("test ext done");
    endtask
    initial begin
        repeat (10) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_legacy();
        t_mask();
        t_ext();
        complete_run();
    end
endmodule // tb_can_interrupt_code_encoder
